// ==== rtl/sbtc_consts.vh ====
`ifndef SBTC_CONSTS_VH
`define SBTC_CONSTS_VH
// register indices (byte address is four times the index)
`define SBTC_IDX_INTCTL 8'h0b
`define SBTC_IDX_IRQFLG 8'h0c
`define SBTC_IDX_CNTLO 8'h0e
`define SBTC_IDX_CNTHI 8'h0f
`define SBTC_IDX_CTRL 8'h10
`define SBTC_IDX_IRQEN 8'h8c
`define SBTC_IDX_CAPCMP 8'h90
`define SBTC_IDX_CMPLO 8'h91
`define SBTC_IDX_CMPHI 8'h92
// counter_control fields
`define SBTC_CTRL_ON 0
`define SBTC_CTRL_CS 1
`define SBTC_CTRL_NOSYNC 2
`define SBTC_CTRL_OSCEN 3
`define SBTC_CTRL_PS_LO 4
`define SBTC_CTRL_PS_HI 5
`define SBTC_CTRL_MASK 8'h3f
`define SBTC_CTRL_RST 8'h00
// flag and enable bit position
`define SBTC_OVF_BIT 0
`define SBTC_IRQ_RST 8'h00
// interrupt_control fields
`define SBTC_INT_GIE 7
`define SBTC_INT_PEIE 6
// compare mode that issues the special event trigger
`define SBTC_MODE_SPECIAL 4'hb
// instruction cycle is four system clocks
`define SBTC_FOSC_HZ 20000000
`define SBTC_INSTR_DIV 4
`define SBTC_OSC_MAX_HZ 200000
`endif

// ==== rtl/sbtc_sync2.v ====
`timescale 1ns/1ns
// ****************************************
// two-flop level synchroniser
// ****************************************
module sbtc_sync2
(
   input wire clk_i,
   input wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;
   always @(posedge clk_i)
   begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
   end
   assign q_o = sync_reg;
endmodule

// ==== rtl/sbtc_prescaler.v ====
`timescale 1ns/1ns
`include "sbtc_consts.vh"
// ****************************************
// input prescaler 1:1 / 1:2 / 1:4 / 1:8
// ****************************************
module sbtc_prescaler
#(
   parameter WIDTH = 3
)
(
   input wire clk_i,
   input wire clr_i,
   input wire tick_i,
   input wire [1:0] sel_i,
   output wire tick_o
);
   reg [WIDTH-1:0] cnt_reg;
   reg [WIDTH-1:0] lim;
   always @*
   begin
      case (sel_i)
         2'h0: lim = {WIDTH{1'b0}};
         2'h1: lim = {{(WIDTH-1){1'b0}}, 1'b1};
         2'h2: lim = {{(WIDTH-2){1'b0}}, 2'h3};
         default: lim = {WIDTH{1'b1}};
      endcase
   end
   assign tick_o = tick_i && (cnt_reg == lim);
   always @(posedge clk_i)
   begin
      if (clr_i)
         cnt_reg <= {WIDTH{1'b0}};
      else if (tick_o)
         cnt_reg <= {WIDTH{1'b0}};
      else if (tick_i)
         cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
   end
endmodule

// ==== rtl/sbtc_timer.v ====
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "sbtc_consts.vh"
// How it works
// - async mode counts ext clock through the same two-flop synchroniser, runs in sleep, overflow wakes cpu
// - in async mode count is not offered as capture/compare time base
// - count byte reads in async mode always return a clean byte
// - crystal oscillator enabled by its bit, up to 200 kHz, runs in sleep
// - compare mode 1011 special event trigger clears the count
// - trigger clear does not set the overflow flag itself; an increment at FFFFh in the same cycle still sets it
// - trigger clear guaranteed only in timer or synchronised counter mode
// - count write in same cycle as trigger clear wins
// - reset leaves count bytes unchanged; only trigger clears them
// - control register zero on power-on reset, kept on other resets
// - writing either count byte clears the prescaler
// - low byte, high byte, control at consecutive addresses; count powers up unknown
// - clock-source clear counts instruction cycles, set counts ext rising edges
// - count wraps FFFFh to 0000h, setting overflow flag; enable with GIE and PEIE both set raises interrupt
// - counter-on bit runs the count; clear holds the value
module sbtc_timer
(
   input wire clk_i,
   input wire rst_i,
   input wire por_i,
   input wire sleep_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [9:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   output wire err_o,
   input wire ext_count_clock_pin_i,
   input wire osc_input_pin_i,
   input wire special_event_i,
   output wire osc_output_pin_o,
   output wire osc_output_pin_oe_o,
   output wire osc_amp_enable_o,
   output wire [15:0] timebase_o,
   output wire timebase_valid_o,
   output wire special_event_o,
   output wire irq_o,
   output wire wake_o
);
   // ****************************************
   // registers
   // ****************************************
   reg [15:0] count_reg;
   reg [7:0] ctrl_reg;
   reg [7:0] intctl_reg;
   reg ovf_flag_reg;
   reg ovf_en_reg;
   reg [3:0] capcmp_mode_reg;
   reg [15:0] cmp_val_reg;
   reg ack_reg;
   reg clk_prev_reg;
   reg [1:0] instr_cnt_reg;
   reg [7:0] rd_next;
   wire ext_pin_sync;
   wire osc_pin_sync;
   wire ext_level;
   wire ext_rise;
   wire instr_tick;
   wire raw_tick;
   wire pre_tick;
   wire inc;
   wire wr_lo;
   wire wr_hi;
   wire wr_any;
   wire sev_clear;
   wire wrap;
   wire async_mode;
   wire counting;
   wire [7:0] idx;
   wire hit;
   wire req;
   // ****************************************
   // wishbone decode
   // ****************************************
   assign idx = adr_i[9:2];
   assign req = cyc_i && stb_i && !ack_reg;
   assign hit = (idx == `SBTC_IDX_INTCTL) || (idx == `SBTC_IDX_IRQFLG) || (idx == `SBTC_IDX_CNTLO) ||
                (idx == `SBTC_IDX_CNTHI) || (idx == `SBTC_IDX_CTRL) || (idx == `SBTC_IDX_IRQEN) ||
                (idx == `SBTC_IDX_CAPCMP) || (idx == `SBTC_IDX_CMPLO) || (idx == `SBTC_IDX_CMPHI);
   assign ack_o = ack_reg && hit;
   assign err_o = ack_reg && !hit;
   wire wr_ok;
   assign wr_ok = req && we_i && sel_i[0];
   assign wr_lo = wr_ok && (idx == `SBTC_IDX_CNTLO);
   assign wr_hi = wr_ok && (idx == `SBTC_IDX_CNTHI);
   assign wr_any = wr_lo || wr_hi;
   always @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= req;
   end
   // ****************************************
   // clock sources
   // ****************************************
   // oscillator pins become inputs while the crystal runs
   assign osc_amp_enable_o = ctrl_reg[`SBTC_CTRL_OSCEN];
   assign osc_output_pin_o = 1'b0;
   assign osc_output_pin_oe_o = 1'b0;
   sbtc_sync2 u_sync_ext
   (
      .clk_i(clk_i),
      .d_i(ext_count_clock_pin_i),
      .q_o(ext_pin_sync)
   );
   sbtc_sync2 u_sync_osc
   (
      .clk_i(clk_i),
      .d_i(osc_input_pin_i),
      .q_o(osc_pin_sync)
   );
   assign ext_level = ctrl_reg[`SBTC_CTRL_OSCEN] ? osc_pin_sync : ext_pin_sync;
   assign ext_rise = ext_level && !clk_prev_reg;
   assign instr_tick = (instr_cnt_reg == 2'h3);
   always @(posedge clk_i)
   begin
      clk_prev_reg <= ext_level;
      if (rst_i)
         instr_cnt_reg <= 2'h0;
      else
         instr_cnt_reg <= instr_cnt_reg + 2'h1;
   end
   assign async_mode = ctrl_reg[`SBTC_CTRL_CS] && ctrl_reg[`SBTC_CTRL_NOSYNC];
   assign raw_tick = ctrl_reg[`SBTC_CTRL_CS] ? ext_rise : instr_tick;
   sbtc_prescaler #(.WIDTH(3)) u_pre
   (
      .clk_i(clk_i),
      .clr_i(wr_any || rst_i),
      .tick_i(raw_tick),
      .sel_i(ctrl_reg[`SBTC_CTRL_PS_HI:`SBTC_CTRL_PS_LO]),
      .tick_o(pre_tick)
   );
   // in sleep only the async (no-sync external clock) counter mode keeps running
   assign counting = ctrl_reg[`SBTC_CTRL_ON] && (!sleep_i || async_mode);
   assign inc = counting && pre_tick;
   assign wrap = inc && (count_reg == 16'hffff);
   // trigger clear only honoured when the count is synchronous
   assign sev_clear = special_event_i && (capcmp_mode_reg == `SBTC_MODE_SPECIAL) && !async_mode;
   assign special_event_o = (capcmp_mode_reg == `SBTC_MODE_SPECIAL) && !async_mode &&
                            (count_reg == cmp_val_reg);
   // ****************************************
   // count register, no reset term
   // ****************************************
   always @(posedge clk_i)
   begin
      if (wr_lo)
         count_reg[7:0] <= dat_i[7:0];
      else if (sev_clear)
         count_reg[7:0] <= 8'h00;
      else if (inc)
         count_reg[7:0] <= count_reg[7:0] + 8'h01;
      if (wr_hi)
         count_reg[15:8] <= dat_i[7:0];
      else if (sev_clear)
         count_reg[15:8] <= 8'h00;
      else if (inc && (count_reg[7:0] == 8'hff) && !wr_lo)
         count_reg[15:8] <= count_reg[15:8] + 8'h01;
   end
   // ****************************************
   // control and interrupt registers
   // ****************************************
   always @(posedge clk_i)
   begin
      if (por_i)
      begin
         ctrl_reg <= `SBTC_CTRL_RST;
         intctl_reg <= `SBTC_IRQ_RST;
         ovf_en_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
         capcmp_mode_reg <= 4'h0;
         cmp_val_reg <= 16'h0000;
      end
      else
      begin
         if (wr_ok && (idx == `SBTC_IDX_CTRL) && !rst_i)
            ctrl_reg <= dat_i[7:0] & `SBTC_CTRL_MASK;
         if (rst_i)
         begin
            intctl_reg <= `SBTC_IRQ_RST;
            ovf_en_reg <= 1'b0;
            ovf_flag_reg <= 1'b0;
         end
         else
         begin
            if (wr_ok && (idx == `SBTC_IDX_INTCTL))
               intctl_reg <= dat_i[7:0];
            if (wr_ok && (idx == `SBTC_IDX_IRQEN))
               ovf_en_reg <= dat_i[`SBTC_OVF_BIT];
            if (wrap)
               ovf_flag_reg <= 1'b1;
            else if (wr_ok && (idx == `SBTC_IDX_IRQFLG) && !dat_i[`SBTC_OVF_BIT])
               ovf_flag_reg <= 1'b0;
            if (wr_ok && (idx == `SBTC_IDX_CAPCMP))
               capcmp_mode_reg <= dat_i[3:0];
            if (wr_ok && (idx == `SBTC_IDX_CMPLO))
               cmp_val_reg[7:0] <= dat_i[7:0];
            if (wr_ok && (idx == `SBTC_IDX_CMPHI))
               cmp_val_reg[15:8] <= dat_i[7:0];
         end
      end
   end
   assign irq_o = ovf_flag_reg && ovf_en_reg && intctl_reg[`SBTC_INT_GIE] && intctl_reg[`SBTC_INT_PEIE];
   assign wake_o = ovf_flag_reg && ovf_en_reg;
   assign timebase_o = count_reg;
   assign timebase_valid_o = !async_mode;
   // ****************************************
   // read mux, registered count byte reads
   // ****************************************
   always @*
   begin
      case (idx)
         `SBTC_IDX_INTCTL: rd_next = intctl_reg;
         `SBTC_IDX_IRQFLG: rd_next = {7'h00, ovf_flag_reg};
         `SBTC_IDX_CNTLO: rd_next = count_reg[7:0];
         `SBTC_IDX_CNTHI: rd_next = count_reg[15:8];
         `SBTC_IDX_CTRL: rd_next = ctrl_reg;
         `SBTC_IDX_IRQEN: rd_next = {7'h00, ovf_en_reg};
         `SBTC_IDX_CAPCMP: rd_next = {4'h0, capcmp_mode_reg};
         `SBTC_IDX_CMPLO: rd_next = cmp_val_reg[7:0];
         `SBTC_IDX_CMPHI: rd_next = cmp_val_reg[15:8];
         default: rd_next = 8'h00;
      endcase
   end
   always @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h00000000;
      else if (req)
         dat_o <= {24'h000000, rd_next};
   end
endmodule

// ==== bench/sbtc_chk.sv ====
`timescale 1ns/1ns
// ****************************************
// port checker of the timer
// ****************************************
module sbtc_chk
(
   input wire clk_i,
   input wire rst_i,
   input wire por_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire err_o,
   input wire special_event_i,
   input wire osc_output_pin_oe_o,
   input wire [15:0] timebase_o,
   input wire timebase_valid_o,
   input wire special_event_o,
   input wire irq_o,
   input wire wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || por_i);
   a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
      else $error("no answer");
   a_resp_exclusive: assert property (!(ack_o && err_o)) else $error("ack with err");
   a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
   a_count_step: assert property ($changed(timebase_o) && !$past(cyc_i && we_i) && !$past(special_event_i)
      |-> timebase_o == $past(timebase_o) + 16'h1) else $error("bad count step");
   a_wrap_flag: assert property ($rose(wake_o)
      |-> $past(timebase_o) == 16'hffff || $past(timebase_o, 2) == 16'hffff) else $error("flag without wrap");
   a_irq_gated: assert property (irq_o |-> wake_o) else $error("irq without flag");
   a_async_no_base: assert property (!timebase_valid_o |-> !special_event_o) else $error("async base");
   a_osc_pin_in: assert property (!osc_output_pin_oe_o) else $error("osc pin driven");
endmodule
bind sbtc_timer sbtc_chk i_sbtc_chk (.clk_i, .rst_i, .por_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .err_o,
   .special_event_i, .osc_output_pin_oe_o, .timebase_o, .timebase_valid_o, .special_event_o, .irq_o, .wake_o);

// ==== bench/sbtc_ext_model.sv ====
`timescale 1ns/1ns
// ****************************************
// external count clock source
// ****************************************
module sbtc_ext_model
(
   input wire logic run_i,
   input wire logic use_osc_i,
   output logic ext_o,
   output logic osc_o
);
   logic ph = 1'b0;
   // 400 ns clock, stands still while not running
   initial
   begin
      #37;
      forever #200 ph = run_i ? ~ph : ph;
   end
   // only the selected pin toggles
   assign ext_o = use_osc_i ? 1'b0 : ph;
   assign osc_o = use_osc_i ? ph : 1'b0;
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
// ****************************************
// timer testbench
// ****************************************
module tb_top;
   logic clk_i = 0, rst_i = 1, por_i = 1, sleep_i = 0, cyc = 0, stb = 0, we = 0, se = 0, run = 0, uo = 0;
   logic [9:0] adr = 0;
   logic [31:0] dat = 0;
   logic [7:0] q;
   logic r;
   logic [15:0] t0;
   wire [31:0] dat_o;
   wire [15:0] tb;
   wire ack_o, err_o, ext, osc, oamp, tbv, irq_o, wake_o, sev;
   int err_count = 0;
   int comparisons = 0;
   always #25 clk_i = ~clk_i;
   sbtc_timer i_sbtc_timer (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .sleep_i(sleep_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .err_o(err_o), .ext_count_clock_pin_i(ext), .osc_input_pin_i(osc), .special_event_i(se),
      .osc_output_pin_o(), .osc_output_pin_oe_o(), .osc_amp_enable_o(oamp), .timebase_o(tb),
      .timebase_valid_o(tbv), .special_event_o(sev), .irq_o(irq_o), .wake_o(wake_o));
   sbtc_ext_model i_sbtc_ext_model (.run_i(run), .use_osc_i(uo), .ext_o(ext), .osc_o(osc));
   task finish_test;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [15:0] g, lo, hi);
      comparisons++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         err_count++;
         $display("CHECK FAILED %0t got %h", $time, g);
      end
   endtask
   // classic cycle, held until ack or err
   task wb(input logic w, input logic [7:0] i, d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {i, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      q = dat_o[7:0];
      r = err_o;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk_i);
   endtask
   task rd(input logic [7:0] i, e);
      wb(0, i, 0);
      chk(q, e, e);
   endtask
   task cnt(input logic [15:0] lo, hi);
      t0 = tb;
      repeat (160) @(posedge clk_i);
      chk(tb - t0, lo, hi);
   endtask
   task rst_pulse(input logic p);
      rst_i <= 1;
      por_i <= p;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      por_i <= 0;
      @(posedge clk_i);
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      por_i <= 0;
      @(posedge clk_i);
      rd(8'h10, 0);
      rd(8'h0c, 0);
      wb(0, 8'h33, 0);
      chk(r, 1, 1);
      wb(1, 8'h10, 8'h30);
      wb(1, 8'h0e, 8'h34);
      wb(1, 8'h0f, 8'h12);
      rst_pulse(0);
      rd(8'h10, 8'h30);
      rd(8'h0e, 8'h34);
      rst_pulse(1);
      rd(8'h10, 0);
      rd(8'h0f, 8'h12);
      for (int p = 0; p < 4; p++)
      begin
         wb(1, 8'h10, {2'b00, p[1:0], 4'h1});
         cnt(40 / (1 << p) - 1, 40 / (1 << p) + 1);
      end
      wb(1, 8'h10, 8'h00);
      cnt(0, 0);
      run <= 1;
      wb(1, 8'h10, 8'h03);
      cnt(19, 21);
      wb(1, 8'h10, 8'h0b);
      uo <= 1;
      repeat (20) @(posedge clk_i);
      chk(oamp, 1, 1);
      cnt(19, 21);
      uo <= 0;
      sleep_i <= 1;
      wb(1, 8'h10, 8'h07);
      cnt(19, 21);
      chk(tbv, 0, 0);
      wb(1, 8'h10, 8'h03);
      cnt(0, 0);
      sleep_i <= 0;
      run <= 0;
      wb(1, 8'h10, 8'h00);
      wb(1, 8'h0e, 8'hf0);
      wb(1, 8'h0f, 8'hff);
      wb(1, 8'h8c, 8'h01);
      wb(1, 8'h0b, 8'hc0);
      wb(1, 8'h10, 8'h01);
      for (int n = 0; n < 200 && irq_o !== 1'b1; n++) @(posedge clk_i);
      chk(irq_o, 1, 1);
      repeat (50) @(posedge clk_i);
      rd(8'h0c, 8'h01);
      wb(1, 8'h0c, 8'h00);
      rd(8'h0c, 8'h00);
      wb(1, 8'h90, 8'h0b);
      repeat (8) @(posedge clk_i);
      se <= 1;
      @(posedge clk_i);
      se <= 0;
      @(posedge clk_i);
      chk(tb, 0, 1);
      rd(8'h0c, 8'h00);
      wb(1, 8'h10, 8'h00);
      wb(1, 8'h0e, 8'h05);
      wb(1, 8'h0f, 8'h00);
      wb(1, 8'h91, 8'h05);
      wb(1, 8'h92, 8'h00);
      chk(sev, 1, 1);
      wb(1, 8'h10, 8'h06);
      chk(sev, 0, 0);
      chk(tbv, 0, 0);
      finish_test;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      finish_test;
   end
endmodule
